// ===== common/lcs_defines.vh
// Constants for the link control and status register pair.
// Assumes a 16-bit configuration access port with byte enables.
// Functional notes
// - Bit 6 records common reference clock; selects reported exit latencies.
// - Retrain bit 5 always reads back zero.
// - Retrain bit clears itself after a one is written.
// - Writing one to retrain drives the training machine into Recovery; lcs_regs drops the request while link-off is one.
// - While link-off bit 4 is one, force Recovery then Disabled.
// - Link-off bit reads back the last written value at once.
// - Clearing link-off retrains the link as after reset.
// - Completion boundary bit 3 is fixed zero, meaning 64 byte.
// - Bits 1:0 select power management; code 10 is reserved.
// - Status bit 12 is read-only one: platform reference clock used.
// - Status bit 11 is set while training runs, cleared when done.
// - Status bit 10 set when training fails to reach L0.
// - Status bits 9:4 report negotiated lane count, reset 00h.
// - Status bits 3:0 report link rate; 1h is 2.5 Gb/s.
`ifndef LCS_DEFINES_VH
`define LCS_DEFINES_VH
`define LCS_OFS_CTRL 8'hB0
`define LCS_OFS_STAT 8'hB2
`define LCS_CTRL_RST 16'h0000
`define LCS_STAT_RST 16'h1001
`define LCS_CTRL_WMASK 16'h0073
`define LCS_B_CCLK 6
`define LCS_B_RETRAIN 5
`define LCS_B_LINKOFF 4
`define LCS_B_RDBOUND 3
`define LCS_F_ASPM_HI 1
`define LCS_F_ASPM_LO 0
`define LCS_ASPM_RSVD 2'h2
`define LCS_B_SLOTCLK 12
`define LCS_B_TRAIN 11
`define LCS_B_TERR 10
`define LCS_WIDTH_RST 6'h00
`define LCS_SPEED_RST 4'h1
`define LCS_L0S_LAT_COMMON 3'h2
`define LCS_L0S_LAT_ASYNC 3'h3
`endif

// ===== design/lcs_flag.v
// Sticky status flag: hardware set wins over clear.
// Assumes one clock, asynchronous low reset.
`timescale 1ns/1ns
`default_nettype none
module lcs_flag (
  input wire core_clk,
  input wire nrst,
  input wire setIn,
  input wire clrIn,
  output reg flagOut
);
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flagOut <= 1'b0;
    end else if (setIn) begin
      flagOut <= 1'b1;
    end else if (clrIn) begin
      flagOut <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== design/lcs_regs.v
// Link control and status registers with training machine steering.
// Assumes the configuration port and training machine share core_clk.
`timescale 1ns/1ns
`default_nettype none
`include "lcs_defines.vh"
module lcs_regs (
  input wire core_clk,
  input wire nrst,
  input wire cfgWr,
  input wire cfgRd,
  input wire [7:0] cfgAddr,
  input wire [1:0] cfgBe,
  input wire [15:0] cfgWdata,
  output reg [15:0] cfgRdata,
  input wire ltssmInL0,
  input wire ltssmTrainDone,
  input wire ltssmTrainFail,
  input wire [5:0] negWidth,
  input wire [3:0] negSpeed,
  input wire negValid,
  output wire retrainReq,
  output wire linkOffReq,
  output wire autoRetrainReq,
  output wire [1:0] aspmCtrl,
  output wire commonClk,
  output wire [2:0] l0sExitLat
);
  reg [15:0] ctrl_reg;
  reg retrainPulse_reg;
  reg autoRetrain_reg;
  reg training_reg;
  reg [5:0] width_reg;
  reg [3:0] speed_reg;
  wire ctrlWr;
  wire [15:0] wmask;
  wire trainErr;
  wire [15:0] statVal;
  wire [1:0] aspmNew;

  assign ctrlWr = cfgWr && (cfgAddr == `LCS_OFS_CTRL);
  // Status writes decode to nothing
  assign wmask = {{8{cfgBe[1]}}, {8{cfgBe[0]}}} & `LCS_CTRL_WMASK;
  assign aspmNew = cfgWdata[`LCS_F_ASPM_HI:`LCS_F_ASPM_LO];

  // Retrain field is never stored, so it reads zero and needs no clearing
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= `LCS_CTRL_RST;
    end else if (ctrlWr) begin
      ctrl_reg[`LCS_B_CCLK] <= wmask[`LCS_B_CCLK] ? cfgWdata[`LCS_B_CCLK]
                                                 : ctrl_reg[`LCS_B_CCLK];
      ctrl_reg[`LCS_B_LINKOFF] <= wmask[`LCS_B_LINKOFF] ? cfgWdata[`LCS_B_LINKOFF]
                                                       : ctrl_reg[`LCS_B_LINKOFF];
      // Reserved code is kept out so hardware never sees it
      if (wmask[0] && aspmNew != `LCS_ASPM_RSVD) begin
        ctrl_reg[`LCS_F_ASPM_HI:`LCS_F_ASPM_LO] <= aspmNew;
      end
    end
  end

  // One-cycle request; self clearing
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      retrainPulse_reg <= 1'b0;
    end else begin
      retrainPulse_reg <= ctrlWr && wmask[`LCS_B_RETRAIN] && cfgWdata[`LCS_B_RETRAIN];
    end
  end
  assign retrainReq = retrainPulse_reg && !ctrl_reg[`LCS_B_LINKOFF];
  assign linkOffReq = ctrl_reg[`LCS_B_LINKOFF];

  // Falling link-off starts reset-style training
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      autoRetrain_reg <= 1'b0;
    end else begin
      autoRetrain_reg <= ctrlWr && wmask[`LCS_B_LINKOFF] && ctrl_reg[`LCS_B_LINKOFF]
                         && !cfgWdata[`LCS_B_LINKOFF];
    end
  end
  assign autoRetrainReq = autoRetrain_reg;

  assign aspmCtrl = ctrl_reg[`LCS_F_ASPM_HI:`LCS_F_ASPM_LO];
  assign commonClk = ctrl_reg[`LCS_B_CCLK];
  assign l0sExitLat = ctrl_reg[`LCS_B_CCLK] ? `LCS_L0S_LAT_COMMON
                                            : `LCS_L0S_LAT_ASYNC;

  // Training in progress from a retrain or auto-retrain request until done or failed
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      training_reg <= 1'b0;
    end else if (retrainReq || autoRetrainReq) begin
      training_reg <= 1'b1;
    end else if (ltssmTrainDone || ltssmTrainFail) begin
      training_reg <= 1'b0;
    end
  end

  // Error stays until a later training reaches L0
  lcs_flag errFlag (
    .core_clk(core_clk),
    .nrst(nrst),
    .setIn(ltssmTrainFail && !ltssmInL0),
    .clrIn(ltssmTrainDone && ltssmInL0),
    .flagOut(trainErr)
  );

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      width_reg <= `LCS_WIDTH_RST;
      speed_reg <= `LCS_SPEED_RST;
    end else if (negValid) begin
      width_reg <= negWidth;
      speed_reg <= negSpeed;
    end
  end

  assign statVal = {3'h0, 1'b1, training_reg, trainErr, width_reg, speed_reg};

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfgRdata <= 16'h0000;
    end else if (cfgRd) begin
      if (cfgAddr == `LCS_OFS_CTRL) begin
        // Bits 5, 3 and reserved read zero
        cfgRdata <= {9'h000, ctrl_reg[`LCS_B_CCLK], 1'b0, ctrl_reg[`LCS_B_LINKOFF],
                     1'b0, 1'b0, ctrl_reg[1:0]};
      end else if (cfgAddr == `LCS_OFS_STAT) begin
        cfgRdata <= statVal;
      end else begin
        cfgRdata <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/lcs_regs_chk.sv
// Checker on the link register ports.
// Assumes a bind onto lcs_regs.
`timescale 1ns/1ns
`default_nettype none
module lcs_regs_chk (input wire core_clk, nrst, cfgWr, cfgRd, input wire [7:0] cfgAddr,
  input wire [1:0] cfgBe, input wire [15:0] cfgWdata, cfgRdata, input wire ltssmInL0,
  ltssmTrainDone, ltssmTrainFail, negValid, retrainReq, linkOffReq, autoRetrainReq,
  commonClk, input wire [5:0] negWidth, input wire [3:0] negSpeed,
  input wire [1:0] aspmCtrl, input wire [2:0] l0sExitLat);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire ctrlWr = cfgWr && cfgAddr == 8'hB0 && cfgBe[0];
  a_retrain_start: assert property (
    ctrlWr && cfgWdata[5] && !cfgWdata[4] && !linkOffReq |=> retrainReq) else $error("no retrain");
  a_retrain_cause: assert property (
    retrainReq |-> $past(ctrlWr)) else $error("stray retrain");
  a_linkoff_echo: assert property (
    ctrlWr |=> linkOffReq == $past(cfgWdata[4])) else $error("link-off echo");
  a_auto_retrain: assert property (
    ctrlWr && !cfgWdata[4] && linkOffReq |=> autoRetrainReq) else $error("no auto retrain");
  a_aspm_keep: assert property (
    ctrlWr && cfgWdata[1:0] == 2'h2 |=> $stable(aspmCtrl)) else $error("aspm taken");
  a_exit_lat: assert property (
    l0sExitLat == (commonClk ? 3'h2 : 3'h3)) else $error("exit latency");
  // Read data reflects the register as it stood at the read edge
  a_ctrl_read: assert property (
    cfgRd && cfgAddr == 8'hB0 |=> cfgRdata == {9'h000, $past(commonClk), 1'h0,
    $past(linkOffReq), 2'h0, $past(aspmCtrl)}) else $error("ctrl read");
  a_stat_top: assert property (
    cfgRd && cfgAddr == 8'hB2 |=> cfgRdata[15:12] == 4'h1) else $error("status top");
endmodule
bind lcs_regs lcs_regs_chk u_chk (.*);
`default_nettype wire

// ===== tb/lcs_ltssm_model.sv
// Training machine stand-in on the far side.
// Assumes go carries every request that leaves L0.
`timescale 1ns/1ns
`default_nettype none
module lcs_ltssm_model (input wire core_clk, nrst, go, failMode,
  output logic ltssmInL0, ltssmTrainDone, ltssmTrainFail, negValid,
  output logic [5:0] negWidth, output logic [3:0] negSpeed);
  logic [2:0] cnt;
  assign ltssmInL0 = cnt == 3'h0 && !failMode;
  assign ltssmTrainDone = cnt == 3'h1 && !failMode;
  assign ltssmTrainFail = cnt == 3'h1 && failMode;
  assign negValid = ltssmTrainDone;
  // Junk outside the valid pulse so a stale capture shows
  assign negWidth = negValid ? 6'h10 : 6'h2A;
  assign negSpeed = negValid ? 4'h1 : 4'hE;
  always @(posedge core_clk or negedge nrst)
    if (!nrst) cnt <= 3'h0;
    else if (go) cnt <= 3'h5;
    else if (cnt != 3'h0) cnt <= cnt - 3'h1;
endmodule
`default_nettype wire

// ===== tb/link_control_status_regs_bench.sv
// Bench for the link control and status registers.
// Assumes lcs_regs with the training model on its far side.
`timescale 1ns/1ns
`default_nettype none
module link_control_status_regs_bench;
  logic core_clk = 1'b0, nrst = 1'b0, cfgWr = 1'b0, cfgRd = 1'b0, failMode = 1'b0;
  logic [7:0] cfgAddr = 8'h00;
  logic [1:0] cfgBe = 2'h3, g;
  logic [15:0] cfgWdata = 16'h0000, cfgRdata;
  logic ltssmInL0, ltssmTrainDone, ltssmTrainFail, negValid, retrainReq, linkOffReq;
  logic autoRetrainReq, commonClk;
  logic [5:0] negWidth;
  logic [3:0] negSpeed;
  logic [1:0] aspmCtrl;
  logic [2:0] l0sExitLat;
  int n_fail = 0, total_checks = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  lcs_regs u_dut (.*);
  lcs_ltssm_model u_link (.go(retrainReq | autoRetrainReq | linkOffReq), .*);
  task wr(input [7:0] a, input [15:0] d);
    @(posedge core_clk) begin cfgWr <= 1'b1; cfgAddr <= a; cfgWdata <= d; end
    @(posedge core_clk) cfgWr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [15:0] e);
    @(posedge core_clk) begin cfgRd <= 1'b1; cfgAddr <= a; end
    @(posedge core_clk) cfgRd <= 1'b0;
    #1 total_checks++;
    if (cfgRdata !== e) begin n_fail++; $display("ERROR reg %h exp %h got %h", a, e, cfgRdata); end
  endtask
  task report_and_stop;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 2000) begin n_fail++; report_and_stop; end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    rd(8'hB0, 16'h0000);
    rd(8'hB2, 16'h1001);
    wr(8'hB0, 16'hFFFF);
    rd(8'hB0, 16'h0053);
    wr(8'hB0, 16'h0043);
    @(posedge core_clk);
    rd(8'hB2, 16'h1801);
    repeat (8) @(posedge core_clk);
    rd(8'hB2, 16'h1101);
    $display("link-off test done");
    @(posedge core_clk) failMode <= 1'b1;
    wr(8'hB0, 16'h0020);
    rd(8'hB0, 16'h0000);
    repeat (8) @(posedge core_clk);
    rd(8'hB2, 16'h1501);
    $display("retrain test done");
    for (int i = 0; i < 4; i++) begin
      g = 2'(i ^ (i >> 1));
      wr(8'hB0, {14'h0000, g});
      rd(8'hB0, {14'h0000, g == 2'h2 ? 2'h3 : g});
    end
    // Upper byte only: the low control byte must not move
    @(posedge core_clk) cfgBe <= 2'h2;
    wr(8'hB0, 16'h0070);
    @(posedge core_clk) cfgBe <= 2'h3;
    rd(8'hB0, 16'h0003);
    wr(8'hB2, 16'h0000);
    rd(8'hB2, 16'h1501);
    rd(8'hB4, 16'h0000);
    $display("access test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
